// ==== verilog/sync_serial_pkg.sv ====
package sync_serial_pkg;
    // Register word indices; the byte address is four times the index.
    localparam logic [9:0] IDX_IRQ_FLAGS   = 10'h00c;
    localparam logic [9:0] IDX_RX_STATUS   = 10'h018;
    localparam logic [9:0] IDX_TX_HOLD     = 10'h019;
    localparam logic [9:0] IDX_RX_BUFFER   = 10'h01a;
    localparam logic [9:0] IDX_IRQ_ENABLES = 10'h08c;
    localparam logic [9:0] IDX_TX_STATUS   = 10'h098;
    localparam logic [9:0] IDX_BAUD_DIV    = 10'h099;

    localparam int ADDR_W   = 12;
    localparam int IDX_LSB  = 2;
    localparam int BIT_RECEIVE_IRQ_FLAG = 5;
    localparam int BIT_TRANSMIT_IRQ_FLAG = 4;
    localparam int BIT_SERIAL_PORT_ENABLE = 7;
    localparam int BIT_RX9  = 6;
    localparam int BIT_CONTINUOUS_RECEIVE_ENABLE = 4;
    localparam int BIT_OVERRUN_ERROR_FLAG = 1;
    localparam int BIT_RECEIVED_NINTH_BIT = 0;
    localparam int BIT_CLOCK_SOURCE_SELECT = 7;
    localparam int BIT_TX9  = 6;
    localparam int BIT_TRANSMIT_ENABLE_BIT = 5;
    localparam int BIT_SYNC = 4;
    localparam int BIT_SHIFT_REG_EMPTY = 1;
    localparam int BIT_TRANSMIT_NINTH_BIT = 0;
    localparam int NINTH    = 8;

    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [7:0] RECEIVE_STATUS_CONTROL_WMASK  = 8'hf8;
    localparam logic [7:0] TRANSMIT_STATUS_CONTROL_WMASK  = 8'hf5;
    localparam logic [3:0] LEN_EIGHT    = 4'h8;
    localparam logic [3:0] LEN_NINE     = 4'h9;
    localparam logic [3:0] CNT_ZERO     = 4'h0;
    localparam logic [3:0] CNT_ONE      = 4'h1;
    localparam logic [1:0] FIFO_DEPTH   = 2'h2;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
    localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;

    typedef enum logic [0:0] {
        TX_IDLE  = 1'h0,
        TX_SHIFT = 1'h1
    } tx_state_t;
endpackage : sync_serial_pkg

// ==== verilog/pin_sync.sv ====
`timescale 1ns/100ps
// Three-stage input synchroniser; the output follows once stages two and three agree.
module pin_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] stable_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q       <= '0;
            s2_q       <= '0;
            s3_q       <= '0;
            stable_out <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    stable_out[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : pin_sync

// ==== verilog/rx_fifo.sv ====
`timescale 1ns/100ps
// Two-word receive buffer holding the data byte and the ninth bit.
module rx_fifo (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       push,
    input  wire logic [8:0] push_data,
    input  wire logic       pop,
    output logic            full,
    output logic            not_empty,
    output logic      [8:0] head
);
    logic [8:0] mem [2];
    logic       wr_ptr_q;
    logic       rd_ptr_q;
    logic [1:0] count_q;
    logic       do_pop;

    assign do_pop    = pop && not_empty;
    assign full      = (count_q == sync_serial_pkg::FIFO_DEPTH);
    assign not_empty = (count_q != 2'h0);
    assign head      = mem[rd_ptr_q];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem[0]   <= 9'h000;
            mem[1]   <= 9'h000;
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= 2'h0;
        end else begin
            if (push) begin
                mem[wr_ptr_q] <= push_data;
                wr_ptr_q      <= ~wr_ptr_q;
            end
            if (do_pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            if (push && !do_pop) begin
                count_q <= count_q + 2'h1;
            end else if (do_pop && !push) begin
                count_q <= count_q - 2'h1;
            end
        end
    end
endmodule : rx_fifo

// ==== verilog/sync_serial_slave_port.sv ====
`timescale 1ns/100ps
module sync_serial_slave_port (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic      [1:0]  bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        serial_clock_pin_i,
    input  wire logic        serial_data_pin_i,
    output logic             serial_data_pin_o,
    output logic             serial_data_pin_oe,
    input  wire logic        core_sleeping,
    input  wire logic        global_irq_enable,
    output logic             wake_request,
    output logic             irq_request
);
    logic [7:0]  receive_status_control_q;
    logic [7:0]  transmit_status_control_q;
    logic [7:0]  pie_q;
    logic [7:0]  baud_q;
    logic [7:0]  hold_q;
    logic        hold_nine_q;
    logic        hold_full_q;
    logic [8:0]  tsr_q;
    logic [3:0]  tx_cnt_q;
    logic [3:0]  tx_len_q;
    sync_serial_pkg::tx_state_t tx_state_q;
    logic [8:0]  rsr_q;
    logic [3:0]  rx_cnt_q;
    logic        overrun_error_flag_q;
    logic        transmit_irq_flag_q;
    logic        ck_prev_q;
    logic [11:0] aw_addr_q;
    logic [7:0]  w_data_q;
    logic        w_lane_q;
    logic [1:0]  pins_sync;
    logic        ck_fall;
    logic        port_on;
    logic        tx_on;
    logic        rx_on;
    logic [3:0]  rx_len;
    logic [8:0]  rx_word;
    logic        rx_done;
    logic        push;
    logic        pop;
    logic        fifo_full;
    logic        receive_irq_flag;
    logic [8:0]  fifo_head;
    logic        do_write;
    logic [9:0]  wr_idx;
    logic        wr_byte;
    logic [9:0]  rd_idx;
    logic [7:0]  rd_val;
    logic        rd_hit;
    logic        load_tsr;

    function automatic logic [9:0] idx_of(input logic [11:0] addr);
        return addr[sync_serial_pkg::ADDR_W-1:sync_serial_pkg::IDX_LSB];
    endfunction : idx_of

    function automatic logic mapped(input logic [9:0] idx);
        return idx inside {sync_serial_pkg::IDX_IRQ_FLAGS, sync_serial_pkg::IDX_RX_STATUS,
                           sync_serial_pkg::IDX_TX_HOLD, sync_serial_pkg::IDX_RX_BUFFER,
                           sync_serial_pkg::IDX_IRQ_ENABLES, sync_serial_pkg::IDX_TX_STATUS,
                           sync_serial_pkg::IDX_BAUD_DIV};
    endfunction : mapped

    pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .async_in  ({serial_clock_pin_i, serial_data_pin_i}),
        .stable_out(pins_sync)
    );

    // Shift clock edges are found by the core clock; the slave never drives the clock.
    assign ck_fall = ck_prev_q && !pins_sync[1];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ck_prev_q <= 1'b0;
        end else begin
            ck_prev_q <= pins_sync[1];
        end
    end

    // Slave mode needs sync and port enable with clock select clear.
    assign port_on = receive_status_control_q[sync_serial_pkg::BIT_SERIAL_PORT_ENABLE] && transmit_status_control_q[sync_serial_pkg::BIT_SYNC]
                     && !transmit_status_control_q[sync_serial_pkg::BIT_CLOCK_SOURCE_SELECT];
    assign tx_on   = port_on && transmit_status_control_q[sync_serial_pkg::BIT_TRANSMIT_ENABLE_BIT];
    // Single receive is not looked at; core sleep does not stop reception.
    assign rx_on   = port_on && receive_status_control_q[sync_serial_pkg::BIT_CONTINUOUS_RECEIVE_ENABLE] && !overrun_error_flag_q;
    assign rx_len  = receive_status_control_q[sync_serial_pkg::BIT_RX9] ? sync_serial_pkg::LEN_NINE : sync_serial_pkg::LEN_EIGHT;

    always_comb begin
        rx_word           = rsr_q;
        rx_word[rx_cnt_q] = pins_sync[0];
    end

    assign rx_done = rx_on && ck_fall && (rx_cnt_q == rx_len - sync_serial_pkg::CNT_ONE);
    assign push    = rx_done && (!fifo_full || pop);

    // Receive shifting: one bit per falling shift clock edge.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rsr_q    <= 9'h000;
            rx_cnt_q <= sync_serial_pkg::CNT_ZERO;
        end else if (!rx_on) begin
            rx_cnt_q <= sync_serial_pkg::CNT_ZERO;
        end else if (ck_fall) begin
            rsr_q[rx_cnt_q] <= pins_sync[0];
            rx_cnt_q        <= rx_done ? sync_serial_pkg::CNT_ZERO : rx_cnt_q + sync_serial_pkg::CNT_ONE;
        end
    end

    // Overrun loses the word and holds off reception until continuous receive drops.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overrun_error_flag_q <= 1'b0;
        end else if (rx_done && !push) begin
            overrun_error_flag_q <= 1'b1;
        end else if (!receive_status_control_q[sync_serial_pkg::BIT_CONTINUOUS_RECEIVE_ENABLE]) begin
            overrun_error_flag_q <= 1'b0;
        end
    end

    rx_fifo u_rx_fifo (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .push     (push),
        .push_data({receive_status_control_q[sync_serial_pkg::BIT_RX9] && rx_word[sync_serial_pkg::NINTH], rx_word[7:0]}),
        .pop      (pop),
        .full     (fifo_full),
        .not_empty(receive_irq_flag),
        .head     (fifo_head)
    );

    // Transmit: holding register to shift register, one bit per falling edge.
    assign load_tsr = tx_on && hold_full_q && (tx_state_q == sync_serial_pkg::TX_IDLE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_state_q <= sync_serial_pkg::TX_IDLE;
            tsr_q      <= 9'h000;
            tx_cnt_q   <= sync_serial_pkg::CNT_ZERO;
            tx_len_q   <= sync_serial_pkg::LEN_EIGHT;
        end else if (!tx_on) begin
            tx_state_q <= sync_serial_pkg::TX_IDLE;
        end else begin
            unique case (tx_state_q)
                sync_serial_pkg::TX_IDLE: begin
                    if (hold_full_q) begin
                        tsr_q      <= {hold_nine_q, hold_q};
                        tx_cnt_q   <= sync_serial_pkg::CNT_ZERO;
                        tx_len_q   <= transmit_status_control_q[sync_serial_pkg::BIT_TX9] ? sync_serial_pkg::LEN_NINE
                                                                         : sync_serial_pkg::LEN_EIGHT;
                        tx_state_q <= sync_serial_pkg::TX_SHIFT;
                    end
                end
                sync_serial_pkg::TX_SHIFT: begin
                    if (ck_fall) begin
                        tsr_q    <= tsr_q >> 1;
                        tx_cnt_q <= tx_cnt_q + sync_serial_pkg::CNT_ONE;
                        if (tx_cnt_q == tx_len_q - sync_serial_pkg::CNT_ONE) begin
                            tx_state_q <= sync_serial_pkg::TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // A new write wins over the transfer out of the holding register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_q      <= sync_serial_pkg::RST_BYTE;
            hold_nine_q <= 1'b0;
            hold_full_q <= 1'b0;
        end else if (wr_byte && wr_idx == sync_serial_pkg::IDX_TX_HOLD) begin
            hold_q      <= w_data_q;
            hold_nine_q <= transmit_status_control_q[sync_serial_pkg::BIT_TRANSMIT_NINTH_BIT];
            hold_full_q <= 1'b1;
        end else if (load_tsr) begin
            hold_full_q <= 1'b0;
        end
    end

    // Transmit flag, pins and core requests, all registered.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            transmit_irq_flag_q             <= 1'b0;
            serial_data_pin_o  <= 1'b0;
            serial_data_pin_oe <= 1'b0;
            wake_request       <= 1'b0;
            irq_request        <= 1'b0;
        end else begin
            transmit_irq_flag_q             <= tx_on && !hold_full_q;
            serial_data_pin_o  <= tsr_q[0];
            serial_data_pin_oe <= tx_on && tx_state_q == sync_serial_pkg::TX_SHIFT;
            wake_request       <= core_sleeping && ((transmit_irq_flag_q && pie_q[sync_serial_pkg::BIT_TRANSMIT_IRQ_FLAG])
                                  || (receive_irq_flag && pie_q[sync_serial_pkg::BIT_RECEIVE_IRQ_FLAG]));
            irq_request        <= global_irq_enable && ((transmit_irq_flag_q && pie_q[sync_serial_pkg::BIT_TRANSMIT_IRQ_FLAG])
                                  || (receive_irq_flag && pie_q[sync_serial_pkg::BIT_RECEIVE_IRQ_FLAG]));
        end
    end

    // Bus write side: address and data taken in either order, answered together.
    assign do_write = !awready && !wready && !bvalid;
    assign wr_idx   = idx_of(aw_addr_q);
    assign wr_byte  = do_write && w_lane_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            bvalid    <= 1'b0;
            bresp     <= sync_serial_pkg::RESP_OKAY;
            aw_addr_q <= 12'h000;
            w_data_q  <= sync_serial_pkg::RST_BYTE;
            w_lane_q  <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_addr_q <= awaddr;
                awready   <= 1'b0;
            end
            if (wvalid && wready) begin
                w_data_q <= wdata[7:0];
                w_lane_q <= wstrb[0];
                wready   <= 1'b0;
            end
            if (do_write) begin
                bvalid <= 1'b1;
                bresp  <= mapped(wr_idx) ? sync_serial_pkg::RESP_OKAY : sync_serial_pkg::RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            receive_status_control_q <= sync_serial_pkg::RST_BYTE;
            transmit_status_control_q <= sync_serial_pkg::RST_BYTE;
            pie_q   <= sync_serial_pkg::RST_BYTE;
            baud_q  <= sync_serial_pkg::RST_BYTE;
        end else if (wr_byte) begin
            unique case (wr_idx)
                sync_serial_pkg::IDX_RX_STATUS:   receive_status_control_q <= w_data_q & sync_serial_pkg::RECEIVE_STATUS_CONTROL_WMASK;
                sync_serial_pkg::IDX_TX_STATUS:   transmit_status_control_q <= w_data_q & sync_serial_pkg::TRANSMIT_STATUS_CONTROL_WMASK;
                sync_serial_pkg::IDX_IRQ_ENABLES: pie_q   <= w_data_q;
                sync_serial_pkg::IDX_BAUD_DIV:    baud_q  <= w_data_q;
                default: ;
            endcase
        end
    end

    // Bus read side: reading the receive buffer pops it.
    assign rd_idx = idx_of(araddr);
    assign rd_hit = arvalid && arready;
    assign pop    = rd_hit && rd_idx == sync_serial_pkg::IDX_RX_BUFFER;

    always_comb begin
        rd_val = sync_serial_pkg::RST_BYTE;
        unique case (rd_idx)
            sync_serial_pkg::IDX_IRQ_FLAGS: begin
                rd_val[sync_serial_pkg::BIT_RECEIVE_IRQ_FLAG] = receive_irq_flag;
                rd_val[sync_serial_pkg::BIT_TRANSMIT_IRQ_FLAG] = transmit_irq_flag_q;
            end
            sync_serial_pkg::IDX_RX_STATUS: begin
                rd_val                            = receive_status_control_q;
                rd_val[sync_serial_pkg::BIT_OVERRUN_ERROR_FLAG] = overrun_error_flag_q;
                rd_val[sync_serial_pkg::BIT_RECEIVED_NINTH_BIT] = fifo_head[sync_serial_pkg::NINTH];
            end
            sync_serial_pkg::IDX_RX_BUFFER:   rd_val = fifo_head[7:0];
            sync_serial_pkg::IDX_IRQ_ENABLES: rd_val = pie_q;
            sync_serial_pkg::IDX_TX_STATUS: begin
                rd_val                            = transmit_status_control_q;
                rd_val[sync_serial_pkg::BIT_SHIFT_REG_EMPTY] = tx_state_q == sync_serial_pkg::TX_IDLE;
            end
            sync_serial_pkg::IDX_BAUD_DIV:    rd_val = baud_q;
            default: ;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= sync_serial_pkg::RDATA_ZERO;
            rresp   <= sync_serial_pkg::RESP_OKAY;
        end else if (rd_hit) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h000000, rd_val};
            rresp   <= mapped(rd_idx) ? sync_serial_pkg::RESP_OKAY : sync_serial_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule : sync_serial_slave_port

// ==== sim/sync_serial_slave_port_properties.sv ====
`timescale 1ns/100ps
module sync_serial_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic        serial_data_pin_oe,
    input wire logic        core_sleeping,
    input wire logic        global_irq_enable,
    input wire logic        wake_request,
    input wire logic        irq_request
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence rd_taken;
        arvalid && arready;
    endsequence
    reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=> !bvalid && !rvalid
        && !serial_data_pin_oe && !wake_request && !irq_request) else $error("outputs busy in reset");
    write_resp_a: assert property (wr_taken |-> ##2 bvalid) else $error("write response late");
    resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");
    aw_refuse_a: assert property (bvalid |-> !awready && !wready) else $error("write taken while busy");
    read_resp_a: assert property (rd_taken |=> rvalid) else $error("read response late");
    read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata dropped");
    rd_refuse_a: assert property (rvalid |-> !arready) else $error("read taken while busy");
    irq_gate_a: assert property (irq_request |-> $past(global_irq_enable))
        else $error("irq without global enable");
    wake_gate_a: assert property (wake_request |-> $past(core_sleeping))
        else $error("wake while awake");
    pend_share_a: assert property (wake_request && $past(global_irq_enable) |-> irq_request)
        else $error("wake without irq");
endmodule : sync_serial_checker

bind sync_serial_slave_port sync_serial_checker checker_i (.*);

// ==== sim/sync_master_model.sv ====
`timescale 1ns/100ps
// Clocking master: makes the shift clock only inside frames, bit 0 first.
module sync_master_model (
    input  wire logic dev_oe,
    input  wire logic dev_do,
    output logic      ck_pin,
    output logic      dt_pin
);
    logic drv_en = 1'b0;
    logic drv_bit = 1'b0;
    logic idle_q = 1'b0;

    // A released line shows the inverse of its last bit, never a held value.
    assign dt_pin = dev_oe ? dev_do : (drv_en ? drv_bit : idle_q);

    initial ck_pin = 1'b0;

    task automatic frame(input logic [8:0] w, input int n, output logic [8:0] got);
        got = 9'h000;
        drv_en = 1'b1;
        #3;
        for (int i = 0; i < n; i++) begin
            drv_bit = w[i];
            #20 ck_pin = 1'b1;
            #40 got[i] = dt_pin;
            ck_pin = 1'b0;
            #20;
        end
        drv_en = 1'b0;
        idle_q = ~drv_bit;
        #60;
    endtask : frame
endmodule : sync_master_model

// ==== sim/sync_serial_slave_port_tb.sv ====
`timescale 1ns/100ps
module sync_serial_slave_port_tb;
    typedef struct packed {
        logic [11:0] a;
        logic [7:0]  wd;
        logic [7:0]  rd;
        logic [1:0]  rs;
    } row_t;
    localparam int LIMIT = 3000;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h1;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        core_sleeping = 1'b0, global_irq_enable = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, serial_data_pin_o, serial_data_pin_oe;
    logic        wake_request, irq_request, serial_clock_pin_i, serial_data_pin_i;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [8:0]  got;
    int          errors = 0, n_compared = 0, cyc = 0;
    row_t        rows [7] = '{
        '{12'h264, 8'ha5, 8'ha5, 2'h0},
        '{12'h230, 8'hff, 8'hff, 2'h0},
        '{12'h260, 8'hff, 8'hf7, 2'h0},
        '{12'h060, 8'hff, 8'hf8, 2'h0},
        '{12'h030, 8'hff, 8'h00, 2'h0},
        '{12'h068, 8'h77, 8'h00, 2'h0},
        '{12'h100, 8'h11, 8'h00, 2'h2}};

    always #5 aclk = ~aclk;

    sync_serial_slave_port uut (.*);
    sync_master_model master (
        .dev_oe (serial_data_pin_oe),
        .dev_do (serial_data_pin_o),
        .ck_pin (serial_clock_pin_i),
        .dt_pin (serial_data_pin_i)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] rs);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(32'(bresp), 32'(rs));
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] rs);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, {24'h000000, e});
        chk(32'(rresp), 32'(rs));
    endtask : rd

    task automatic wait_oe();
        for (int k = 0; k < 40 && !serial_data_pin_oe; k++) @(posedge aclk);
        chk(32'(serial_data_pin_oe), 32'h1);
    endtask : wait_oe

    task automatic close_out();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            errors++;
            close_out();
        end
    end

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].wd, rows[i].rs);
            rd(rows[i].a, rows[i].rd, rows[i].rs);
        end
        // Sleeping core with two words queued for transmission.
        wr(12'h260, 8'h71, 2'h0);
        wr(12'h060, 8'h80, 2'h0);
        wr(12'h230, 8'h30, 2'h0);
        core_sleeping <= 1'b1;
        global_irq_enable <= 1'b1;
        wr(12'h064, 8'ha5, 2'h0);
        wr(12'h064, 8'h3c, 2'h0);
        rd(12'h030, 8'h00, 2'h0);
        rd(12'h260, 8'h71, 2'h0);
        chk(32'(wake_request), 32'h0);
        wait_oe();
        master.frame(9'h000, 9, got);
        chk(32'(got), 32'h1a5);
        rd(12'h030, 8'h10, 2'h0);
        chk(32'(wake_request), 32'h1);
        chk(32'(irq_request), 32'h1);
        wait_oe();
        master.frame(9'h000, 9, got);
        chk(32'(got), 32'h13c);
        rd(12'h260, 8'h73, 2'h0);
        // Reception in sleep, single-receive ignored, then an overrun.
        wr(12'h260, 8'h10, 2'h0);
        wr(12'h060, 8'ha0, 2'h0);
        master.frame(9'h0ff, 8, got);
        rd(12'h030, 8'h00, 2'h0);
        wr(12'h060, 8'hc0, 2'h0);
        wr(12'h060, 8'hd0, 2'h0);
        master.frame(9'h155, 9, got);
        rd(12'h030, 8'h20, 2'h0);
        chk(32'(wake_request), 32'h1);
        master.frame(9'h0aa, 9, got);
        master.frame(9'h1ff, 9, got);
        rd(12'h060, 8'hd3, 2'h0);
        rd(12'h068, 8'h55, 2'h0);
        rd(12'h060, 8'hd2, 2'h0);
        rd(12'h068, 8'haa, 2'h0);
        rd(12'h030, 8'h00, 2'h0);
        wr(12'h060, 8'hc0, 2'h0);
        // With the buffer drained, the ninth bit shows the stale word at the read pointer, the first one received.
        rd(12'h060, 8'hc1, 2'h0);
        // Eight-bit reception: eight bits are clocked, and the stale ninth bit left in the shift register is never taken.
        wr(12'h060, 8'h90, 2'h0);
        master.frame(9'h1c3, 8, got);
        rd(12'h060, 8'h90, 2'h0);
        rd(12'h068, 8'hc3, 2'h0);
        // Second reset in mid-run restores every register.
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h030, 8'h00, 2'h0);
        rd(12'h060, 8'h00, 2'h0);
        rd(12'h068, 8'h00, 2'h0);
        rd(12'h230, 8'h00, 2'h0);
        rd(12'h260, 8'h02, 2'h0);
        rd(12'h264, 8'h00, 2'h0);
        close_out();
    end
endmodule : sync_serial_slave_port_tb
